//--- rtl/dpsm_edge_counter.sv
/*
  edge distance counter: counts encoder edges, captures a reference on
  request and reports absolute distance from it.
  assumes edge strobes already synchronised to core_clk.
*/
`timescale 1ns/1ps
`default_nettype none
module dpsm_edge_counter (
  // clock and reset
  input wire logic core_clk,
  input wire logic sys_rst,
  // carrier
  dpsm_cnt_if.cnt cnt
);
  import dpsm_pkg::*;
  logic [POS_W-1:0] pos_ff;
  logic [POS_W-1:0] ref_ff;
  logic [POS_W-1:0] diff;

  // each edge is one distance unit
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      pos_ff <= '0;
    end else if (cnt.edge_pulse) begin
      pos_ff <= cnt.dir_up ? pos_ff + 32'h0000_0001 : pos_ff - 32'h0000_0001;
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      ref_ff <= '0;
    end else if (cnt.capture) begin
      ref_ff <= pos_ff;
    end
  end

  // wraparound subtraction keeps the sign right across counter rollover
  assign diff = pos_ff - ref_ff;
  assign cnt.distance = diff[POS_W-1] ? (~diff + 32'h0000_0001) : diff;
endmodule
`default_nettype wire

//--- rtl/dpsm_if.sv
/*
  interface between the monitor core and its position counter.
  assumes both ends run on core_clk.
*/
`timescale 1ns/1ps
`default_nettype none
interface dpsm_cnt_if;
  logic edge_pulse;
  logic dir_up;
  logic capture;
  logic [31:0] distance;
  modport core (output capture, input distance);
  modport cnt (input edge_pulse, input dir_up, input capture, output distance);
endinterface
`default_nettype wire

//--- rtl/dpsm_pkg.sv
/*
  package for the delayed position safety monitor: states, widths, reset
  values and timing counts. assumes a 100 MHz core clock.
*/
package dpsm_pkg;
  // =====================================================================
  // timing
  localparam int unsigned CLK_HZ = 100_000_000;
  localparam int unsigned TICK_MS = 10;
  localparam int unsigned TICK_CYCLES = CLK_HZ / 1000 * TICK_MS;
  // =====================================================================
  // parameter fields
  localparam int unsigned DIST_W = 16;
  localparam int unsigned TIME_W = 14;
  localparam logic [15:0] DIST_DEFAULT = 16'h000a;
  localparam logic [15:0] DIST_MIN = 16'h0001;
  localparam logic [13:0] DECEL_WAIT_DEFAULT = 14'h0000;
  localparam logic [13:0] DECEL_SUP_DEFAULT = 14'h01f4;
  localparam int unsigned POS_W = 32;
  // =====================================================================
  // channel select and monitor states
  localparam logic CHAN_A = 1'b0;
  localparam logic CHAN_B = 1'b1;
  typedef enum logic [1:0] {
    DPSM_IDLE,
    DPSM_DECEL,
    DPSM_POSMON,
    DPSM_CUTOFF
  } dpsm_state_t;
endpackage

//--- rtl/dpsm_top.sv
/*
  delayed position safety monitor for one axis: deceleration supervision,
  then edge-distance position monitoring, with per-channel alarms and a
  power cutoff command.
  assumes a speed comparator outside supplies speed_over, and that
  parameters are held stable; all but stop_method_select, which passes straight through, are sampled only at reset release.
*/
`timescale 1ns/1ps
`default_nettype none
module dpsm_top #(
  parameter int unsigned TICK_CNT = dpsm_pkg::TICK_CYCLES
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic sys_rst,
  // safety request and servo state (pins, active low = request on)
  input wire logic safety_req_in,
  input wire logic servo_ready_in,
  input wire logic recalc_busy,
  input wire logic speed_over,
  // encoder edges (pins)
  input wire logic enc_edge_in,
  input wire logic enc_dir_in,
  // configuration
  input wire logic chan_select,
  input wire logic [dpsm_pkg::DIST_W-1:0] limited_distance_a,
  input wire logic [dpsm_pkg::DIST_W-1:0] limited_distance_b,
  input wire logic [dpsm_pkg::TIME_W-1:0] decel_wait_time_a,
  input wire logic [dpsm_pkg::TIME_W-1:0] decel_supervise_time_a,
  input wire logic [1:0] stop_method_select,
  input wire logic alarm_reset,
  // status
  output logic delayed_position_monitor,
  output logic power_cutoff_state,
  output logic power_cutoff_cmd,
  output logic monitor_alarm_a,
  output logic monitor_alarm_b,
  output logic param_setting_error,
  output logic ext_device_monitor,
  output logic [1:0] stop_method_out,
  output logic decel_active
);
  import dpsm_pkg::*;

  // =====================================================================
  // pin synchronisers: three stages, change taken when stages 2 and 3 agree
  logic [2:0] req_sync_ff;
  logic [2:0] rdy_sync_ff;
  logic [2:0] edg_sync_ff;
  logic [2:0] dir_sync_ff;
  logic req_ff;
  logic rdy_ff;
  logic edg_ff;
  logic dir_ff;

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      req_sync_ff <= 3'h7;
      rdy_sync_ff <= 3'h0;
      edg_sync_ff <= 3'h0;
      dir_sync_ff <= 3'h0;
    end else begin
      req_sync_ff <= {req_sync_ff[1:0], safety_req_in};
      rdy_sync_ff <= {rdy_sync_ff[1:0], servo_ready_in};
      edg_sync_ff <= {edg_sync_ff[1:0], enc_edge_in};
      dir_sync_ff <= {dir_sync_ff[1:0], enc_dir_in};
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      req_ff <= 1'b1;
      rdy_ff <= 1'b0;
      edg_ff <= 1'b0;
      dir_ff <= 1'b0;
    end else begin
      if (req_sync_ff[1] == req_sync_ff[2]) req_ff <= req_sync_ff[2];
      if (rdy_sync_ff[1] == rdy_sync_ff[2]) rdy_ff <= rdy_sync_ff[2];
      if (edg_sync_ff[1] == edg_sync_ff[2]) edg_ff <= edg_sync_ff[2];
      if (dir_sync_ff[1] == dir_sync_ff[2]) dir_ff <= dir_sync_ff[2];
    end
  end

  // every filtered level change of the encoder line is one edge
  logic edg_prev_ff;
  always_ff @(posedge core_clk) begin
    if (sys_rst) edg_prev_ff <= 1'b0;
    else edg_prev_ff <= edg_ff;
  end

  // an encoder line left high over reset would look like an edge once the
  // synchroniser fills; edges are ignored until chain and filter have settled
  logic [4:0] arm_ff;
  always_ff @(posedge core_clk) begin
    if (sys_rst) arm_ff <= '0;
    else arm_ff <= {arm_ff[3:0], 1'b1};
  end

  // =====================================================================
  // parameter capture one cycle after reset release
  logic loaded_ff;
  logic chan_ff;
  logic [DIST_W-1:0] lim_a_ff;
  logic [DIST_W-1:0] lim_b_ff;
  logic [TIME_W-1:0] wait_ff;
  logic [TIME_W-1:0] sup_ff;

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      loaded_ff <= 1'b0;
      chan_ff <= CHAN_A;
      lim_a_ff <= DIST_DEFAULT;
      lim_b_ff <= DIST_DEFAULT;
      wait_ff <= DECEL_WAIT_DEFAULT;
      sup_ff <= DECEL_SUP_DEFAULT;
    end else if (!loaded_ff) begin
      loaded_ff <= 1'b1;
      chan_ff <= chan_select;
      // zero is outside the legal range, clamp to the smallest distance
      lim_a_ff <= (limited_distance_a == '0) ? DIST_MIN : limited_distance_a;
      lim_b_ff <= (limited_distance_b == '0) ? DIST_MIN : limited_distance_b;
      wait_ff <= decel_wait_time_a;
      sup_ff <= decel_supervise_time_a;
    end
  end

  logic perr_ff;
  always_ff @(posedge core_clk) begin
    if (sys_rst) perr_ff <= 1'b0;
    else if (loaded_ff) perr_ff <= (wait_ff > sup_ff);
  end
  assign param_setting_error = perr_ff;

  // =====================================================================
  // 10 ms tick divider
  logic [31:0] div_ff;
  logic tick;
  assign tick = (div_ff == TICK_CNT - 1);
  always_ff @(posedge core_clk) begin
    if (sys_rst || tick) div_ff <= '0;
    else div_ff <= div_ff + 32'h0000_0001;
  end

  // =====================================================================
  // state machine
  dpsm_cnt_if cif ();
  dpsm_edge_counter u_cnt (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .cnt(cif)
  );
  assign cif.edge_pulse = (edg_ff ^ edg_prev_ff) && arm_ff[4];
  assign cif.dir_up = dir_ff;

  dpsm_state_t state_ff;
  dpsm_state_t nxt_state;
  logic [TIME_W-1:0] t_ff;
  logic alarm_a_ff;
  logic alarm_b_ff;
  logic cut_ff;
  logic [DIST_W-1:0] lim_sel;
  logic dist_over;
  logic speed_trip;
  logic dist_trip;

  assign lim_sel = (chan_ff == CHAN_A) ? lim_a_ff : lim_b_ff;
  assign dist_over = cif.distance > {16'h0000, lim_sel};
  assign speed_trip = (state_ff == DPSM_DECEL) && speed_over && req_ff == 1'b0;
  assign dist_trip = (state_ff == DPSM_POSMON) && dist_over && req_ff == 1'b0;
  assign cif.capture = (state_ff != DPSM_POSMON) && (nxt_state == DPSM_POSMON);

  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      DPSM_IDLE: begin
        if (loaded_ff && !req_ff && !perr_ff) begin
          // servo not ready after reset or during recalculation: no decel phase
          if (!rdy_ff || recalc_busy) nxt_state = DPSM_POSMON;
          else nxt_state = DPSM_DECEL;
        end
      end
      DPSM_DECEL: begin
        if (req_ff) nxt_state = DPSM_IDLE;
        else if (speed_trip) nxt_state = DPSM_CUTOFF;
        else if (tick && t_ff >= sup_ff) nxt_state = DPSM_POSMON;
      end
      DPSM_POSMON: begin
        if (req_ff) nxt_state = DPSM_IDLE;
        else if (dist_trip) nxt_state = DPSM_CUTOFF;
      end
      DPSM_CUTOFF: begin
        // leave only once alarms are reset and the request is back
        if (alarm_reset && req_ff) nxt_state = DPSM_IDLE;
      end
      default: nxt_state = DPSM_IDLE;
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) state_ff <= DPSM_IDLE;
    else state_ff <= nxt_state;
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst || state_ff != DPSM_DECEL) t_ff <= '0;
    else if (tick && t_ff != {TIME_W{1'b1}}) t_ff <= t_ff + 14'h0001;
  end

  // cutoff is driven from the registered cutoff state, one cycle after the
  // decel or position monitoring state has already been left
  always_ff @(posedge core_clk) begin
    if (sys_rst) cut_ff <= 1'b0;
    else cut_ff <= (state_ff == DPSM_CUTOFF);
  end

  // alarm set wins over a coincident reset
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      alarm_a_ff <= 1'b0;
      alarm_b_ff <= 1'b0;
    end else begin
      if ((speed_trip || dist_trip) && chan_ff == CHAN_A) alarm_a_ff <= 1'b1;
      else if (alarm_reset) alarm_a_ff <= 1'b0;
      if ((speed_trip || dist_trip) && chan_ff == CHAN_B) alarm_b_ff <= 1'b1;
      else if (alarm_reset) alarm_b_ff <= 1'b0;
    end
  end

  logic pm_ff;
  logic pc_ff;
  logic dec_ff;
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      pm_ff <= 1'b0;
      pc_ff <= 1'b0;
      dec_ff <= 1'b0;
    end else begin
      pm_ff <= (nxt_state == DPSM_POSMON);
      pc_ff <= (nxt_state == DPSM_CUTOFF);
      dec_ff <= (nxt_state == DPSM_DECEL);
    end
  end

  assign delayed_position_monitor = pm_ff;
  assign power_cutoff_state = pc_ff;
  assign power_cutoff_cmd = cut_ff;
  assign monitor_alarm_a = alarm_a_ff;
  assign monitor_alarm_b = alarm_b_ff;
  assign decel_active = dec_ff;
  // a limit alarm is no internal fault, so the monitor output stays on
  assign ext_device_monitor = 1'b1;
  assign stop_method_out = stop_method_select;
endmodule
`default_nettype wire

//--- sim/dpsm_servo_model.sv
/*
  servo amplifier model: encoder pulse output lines.
  assumes edges spaced wider than the monitor input filter.
*/
`timescale 1ns/1ps
`default_nettype none
module dpsm_servo_model (
  // clock
  input wire logic core_clk,
  // encoder pulse output
  output logic enc_edge,
  output logic enc_dir
);
  initial begin
    enc_edge = 1'b0;
    enc_dir = 1'b1;
  end
  // =====================================================================
  // one level change per distance unit
  task automatic step(input int n, input logic up);
    enc_dir = up;
    repeat (n) begin
      repeat (4) @(negedge core_clk);
      enc_edge = ~enc_edge;
    end
  endtask
endmodule
`default_nettype wire

//--- sim/dpsm_top_chk.sv
/*
  checker for dpsm_top port behaviour, bound to the top module.
  assumes one core_clk domain and sys_rst synchronous active high.
*/
`timescale 1ns/1ps
`default_nettype none
module dpsm_top_chk (
  // clock and reset
  input wire logic core_clk,
  input wire logic sys_rst,
  // inputs
  input wire logic speed_over,
  input wire logic alarm_reset,
  input wire logic [1:0] stop_method_select,
  // status
  input wire logic delayed_position_monitor,
  input wire logic power_cutoff_state,
  input wire logic power_cutoff_cmd,
  input wire logic monitor_alarm_a,
  input wire logic monitor_alarm_b,
  input wire logic param_setting_error,
  input wire logic ext_device_monitor,
  input wire logic [1:0] stop_method_out,
  input wire logic decel_active
);
  // =====================================================================
  // assertions
  default clocking @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  ext_mon_a: assert property (ext_device_monitor)
    else $error("device monitor output dropped");
  cut_cmd_a: assert property ($rose(power_cutoff_state) |->
    !power_cutoff_cmd ##1 power_cutoff_cmd) else $error("cutoff command order");
  cmd_src_a: assert property (power_cutoff_cmd |-> $past(power_cutoff_state))
    else $error("cutoff command without cutoff state");
  state_excl_a: assert property (!(delayed_position_monitor &&
    (power_cutoff_state || decel_active))) else $error("two states at once");
  speed_cut_a: assert property (decel_active && speed_over |->
    ##[1:2] power_cutoff_state) else $error("speed excess not cut");
  alarm_hold_a: assert property ($fell(monitor_alarm_a) |-> $past(alarm_reset))
    else $error("alarm a cleared without reset");
  alarm_b_cut_a: assert property ($rose(monitor_alarm_b) |-> power_cutoff_state)
    else $error("alarm b without cutoff");
  cut_leave_a: assert property ($fell(power_cutoff_state) |->
    $past(alarm_reset) || $past(alarm_reset, 2)) else $error("cutoff left alone");
  perr_block_a: assert property (param_setting_error |->
    !decel_active && !delayed_position_monitor) else $error("started with bad params");
  stop_pass_a: assert property (stop_method_out == stop_method_select)
    else $error("stop method not passed");
  cover property ($rose(decel_active));
  cover property (delayed_position_monitor ##1 power_cutoff_state);
  cover property ($rose(monitor_alarm_b));
endmodule
bind dpsm_top dpsm_top_chk i_chk (.*);
`default_nettype wire

//--- sim/dpsm_top_tb.sv
/*
  self-checking bench for dpsm_top with a servo model on the encoder.
  assumes short tick via TICK_CNT and fixed pin latency of 4 edges.
*/
`timescale 1ns/1ps
`default_nettype none
module dpsm_top_tb;
  import dpsm_pkg::*;
  logic core_clk = 1'b0, sys_rst = 1'b1, req = 1'b1, rdy = 1'b1;
  logic busy = 1'b0, spd = 1'b0, chan = CHAN_A, arst = 1'b0;
  logic [15:0] lim_a = 16'h0004, lim_b = 16'h0004;
  logic [13:0] t_wait = 14'h0001, t_sup = 14'h0003;
  logic [1:0] stop_sel = 2'h0, stop_o;
  wire logic [7:0] st;
  logic edge_w, dir_w;
  logic [7:0] exp_q[$];
  int n_errors = 0, cmp_count = 0, cyc = 0;
  event chk_ev;
  // =====================================================================
  // design and far side
  dpsm_top #(.TICK_CNT(10)) i_dut (.core_clk(core_clk), .sys_rst(sys_rst),
    .safety_req_in(req), .servo_ready_in(rdy), .recalc_busy(busy),
    .speed_over(spd), .enc_edge_in(edge_w), .enc_dir_in(dir_w),
    .chan_select(chan), .limited_distance_a(lim_a), .limited_distance_b(lim_b),
    .decel_wait_time_a(t_wait), .decel_supervise_time_a(t_sup),
    .stop_method_select(stop_sel), .alarm_reset(arst),
    .decel_active(st[7]), .delayed_position_monitor(st[6]),
    .power_cutoff_state(st[5]), .power_cutoff_cmd(st[4]),
    .monitor_alarm_a(st[3]), .monitor_alarm_b(st[2]),
    .param_setting_error(st[1]), .ext_device_monitor(st[0]),
    .stop_method_out(stop_o));
  dpsm_servo_model i_srv (.core_clk(core_clk), .enc_edge(edge_w), .enc_dir(dir_w));
  initial forever #5 core_clk = ~core_clk;
  // =====================================================================
  // helpers
  task automatic cyc_n(input int n);
    repeat (n) @(negedge core_clk);
  endtask
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("MISMATCH t=%0t seen %h exp %h", $time, seen, exp);
    end
  endtask
  task automatic expect_st(input logic [7:0] e);
    exp_q.push_back(e);
    ->chk_ev;
  endtask
  always @(chk_ev) begin
    #1;
    chk(st, exp_q.pop_front());
  end
  task automatic do_reset;
    sys_rst = 1'b1;
    cyc_n(8);
    sys_rst = 1'b0;
    cyc_n(3);
  endtask
  task automatic clear_alarm;
    req = 1'b1;
    cyc_n(8);
    arst = 1'b1;
    cyc_n(1);
    arst = 1'b0;
    cyc_n(3);
    expect_st(8'h01);
  endtask
  task automatic tally_and_finish;
    $display("errors %0d compares %0d", n_errors, cmp_count);
    if (n_errors == 0 && cmp_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 5000) begin
      n_errors++;
      tally_and_finish;
    end
  end
  // =====================================================================
  // scenarios
  initial begin
    void'($urandom(32'h2e90));
    cyc_n(1);
    do_reset;
    expect_st(8'h01);
    req = 1'b0;
    cyc_n(8);
    expect_st(8'h81);
    cyc_n(40);
    expect_st(8'h41);
    req = 1'b1;
    cyc_n(8);
    expect_st(8'h01);
    req = 1'b0;
    cyc_n(8);
    req = 1'b1;
    cyc_n(8);
    expect_st(8'h01);
    req = 1'b0;
    cyc_n(8);
    spd = 1'b1;
    cyc_n(3);
    spd = 1'b0;
    expect_st(8'h39);
    clear_alarm;
    // absolute distance: out and back inside the limit, then one beyond
    rdy = 1'b0;
    req = 1'b0;
    cyc_n(8);
    expect_st(8'h41);
    i_srv.step(4, 1'b1);
    cyc_n(8);
    expect_st(8'h41);
    i_srv.step(8, 1'b0);
    cyc_n(8);
    expect_st(8'h41);
    i_srv.step(1, 1'b0);
    cyc_n(8);
    expect_st(8'h39);
    clear_alarm;
    busy = 1'b1;
    req = 1'b0;
    cyc_n(8);
    expect_st(8'h41);
    req = 1'b1;
    busy = 1'b0;
    cyc_n(8);
    // channel B with a random limit, picked up only at reset
    lim_b = 16'(2 + $urandom % 6);
    stop_sel = 2'($urandom);
    chan = CHAN_B;
    do_reset;
    chk({6'h00, stop_o}, {6'h00, stop_sel});
    req = 1'b0;
    cyc_n(8);
    i_srv.step(int'(lim_b), 1'b1);
    cyc_n(8);
    expect_st(8'h41);
    i_srv.step(1, 1'b1);
    cyc_n(8);
    expect_st(8'h35);
    clear_alarm;
    t_wait = 14'h0005;
    do_reset;
    expect_st(8'h03);
    req = 1'b0;
    cyc_n(8);
    expect_st(8'h03);
    cyc_n(2);
    tally_and_finish;
  end
endmodule
`default_nettype wire
